/* File: logic/ooc_map.svh */
`ifndef OOC_MAP_SVH
`define OOC_MAP_SVH
`define OOC_REG_OP 8'h01
`define OOC_REG_CFG 8'h02
`define OOC_CMD_CLEAR 8'h03
`define OOC_CMD_STORE 8'h11
`define OOC_OP_RST 8'h00
`define OOC_OP_RO_MASK 8'hfc
`define OOC_CFG_RST 5'h16
`define OOC_OP_ON 7
`define OOC_OP_OFF 6
`define OOC_OP_MG_HI 5
`define OOC_OP_MG_LO 2
`define OOC_CFG_PU 4
`define OOC_CFG_CMD 3
`define OOC_CFG_CPR 2
`define OOC_CFG_POL 1
`define OOC_CFG_CPA 0
`define OOC_MG_NOM_A 4'h0
`define OOC_MG_NOM_IGN 4'h1
`define OOC_MG_NOM_B 4'h2
`define OOC_MG_NOM_C 4'h3
`define OOC_MG_LO_IGN 4'h5
`define OOC_MG_LO_ACT 4'h6
`define OOC_MG_HI_IGN 4'h9
`define OOC_MG_HI_ACT 4'ha
`define OOC_BIT_LAST 4'h7
`define OOC_BIT_FULL 4'h8
`define OOC_SYNC_RST 3'h3
`endif

/* File: logic/ooc_pkg.sv */
package ooc_pkg;
    typedef enum logic [4:0] {
        BS_IDLE = 5'h01, BS_RX = 5'h02, BS_ACK = 5'h04, BS_TX = 5'h08, BS_RACK = 5'h10
    } ooc_bus_st_t;
    typedef enum logic [3:0] {
        SQ_OFF = 4'h1, SQ_ON = 4'h2, SQ_DLY = 4'h4, SQ_FALL = 4'h8
    } ooc_seq_st_t;
    typedef enum logic [1:0] {MG_NOM = 2'h0, MG_LO = 2'h1, MG_HI = 2'h2} ooc_mgn_t;
    typedef struct packed {
        logic valid;
        logic ignore;
        ooc_mgn_t sel;
    } ooc_mdec_t;
endpackage

/* File: logic/ooc_seq_if.sv */
interface ooc_seq_if;
    logic run_req;
    logic soft_off;
    logic [15:0] dly;
    logic [15:0] fall;
    logic switching;
    logic ramping;
    modport ctrl(output run_req, output soft_off, output dly, output fall,
                 input switching, input ramping);
    modport seq(input run_req, input soft_off, input dly, input fall,
                output switching, output ramping);
endinterface

/* File: logic/ooc_sync.sv */
`include "ooc_map.svh"
module ooc_sync #(parameter int W = 3) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    // Stages start with SCL and SDA idle high and the control pin low, so no false bus edge follows reset
    localparam logic [W-1:0] RST_Q = W'(`OOC_SYNC_RST);
    // Level only moves once the last two stages agree, filtering one-cycle glitches
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                s1[i] <= RST_Q[i];
                s2[i] <= RST_Q[i];
                s3[i] <= RST_Q[i];
                q_out[i] <= RST_Q[i];
            end else begin
                s1[i] <= d_in[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) q_out[i] <= s2[i];
            end
        end
    end
endmodule

/* File: logic/ooc_seq.sv */
module ooc_seq (
    input wire logic clk_in,
    input wire logic rst_b_in,
    ooc_seq_if.seq sq
);
    ooc_pkg::ooc_seq_st_t st, next_st;
    logic [15:0] cnt, next_cnt;

    always_comb begin
        next_st = st;
        next_cnt = cnt;
        unique case (st)
            ooc_pkg::SQ_OFF: if (sq.run_req) next_st = ooc_pkg::SQ_ON;
            ooc_pkg::SQ_ON: if (!sq.run_req) begin
                if (sq.soft_off) begin // R06
                    next_st = ooc_pkg::SQ_DLY;
                    next_cnt = sq.dly;
                end else begin
                    next_st = ooc_pkg::SQ_OFF; // R05
                end
            end
            ooc_pkg::SQ_DLY, ooc_pkg::SQ_FALL: begin
                // A hard cause arriving mid-ramp still cuts the output at once
                if (sq.run_req) next_st = ooc_pkg::SQ_ON;
                else if (!sq.soft_off) next_st = ooc_pkg::SQ_OFF;
                else if (cnt != 16'h0000) next_cnt = cnt - 16'h0001;
                else if (st == ooc_pkg::SQ_DLY) begin // R06
                    next_st = ooc_pkg::SQ_FALL;
                    next_cnt = sq.fall;
                end else next_st = ooc_pkg::SQ_OFF;
            end
            default: next_st = ooc_pkg::SQ_OFF;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= ooc_pkg::SQ_OFF;
            cnt <= 16'h0000;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
        end
    end

    assign sq.switching = (st != ooc_pkg::SQ_OFF);
    assign sq.ramping = (st == ooc_pkg::SQ_FALL);

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    hard_off_a: assert property ( // R05
        (st == ooc_pkg::SQ_ON && !sq.run_req && !sq.soft_off) |=> !sq.switching)
        else $error("immediate turn-off did not stop switching");
    soft_off_a: assert property ( // R06
        (st == ooc_pkg::SQ_ON && !sq.run_req && sq.soft_off) |=>
        (st == ooc_pkg::SQ_DLY && cnt == $past(sq.dly)))
        else $error("soft turn-off did not enter the delay");
    fall_seen_c: cover property (st == ooc_pkg::SQ_DLY ##1 st == ooc_pkg::SQ_FALL);
endmodule

/* File: logic/ooc_top.sv */
// What this block does
// (R01) Operating state holds until a new on/off-margin write or control pin change.
// (R02) Loop follower NACKs both command codes, flags invalid command, raises alert.
// (R03) Enable bit clear stops switching; both driver enables go low.
// (R04) Enable set starts only above lockout, with command gating, without fault.
// (R05) Turn-off bit clear: command shutdown cuts output at once.
// (R06) Turn-off bit set: command shutdown waits delay, then ramps down.
// (R07) Bits 1 and 0 of on/off-margin are read-only; writes ignored.
// (R08) Enable and turn-off bits both set is invalid data with alert.
// (R09) Margin 0001: nominal setpoint, fault responses ignored, status still flags.
// (R10) Margin 0000, 0010, 0011: nominal setpoint, faults acted upon.
// (R11) Margin 0101 low ignoring faults; 0110 low acting on faults.
// (R12) Margin 1001 high ignoring faults; 1010 high acting on faults.
// (R13) All other margin codes are invalid data.
// (R14) Low target is nominal plus (trim minus low step) scaled down.
// (R15) High target is nominal plus (trim plus high step) scaled down.
// (R16) Ignored faults still set status and alert; only the mask hides alert.
// (R17) Config defaults: pin only, active high, delayed ramped turn-off.
// (R18) Config bits 4:0 writable and storable; bits 7:5 read as zero.
// (R19) Gating bit 0 runs whenever powered; 1 waits for selected sources.
// (R20) Command and pin response bits each make their source required.
// (R21) Pin polarity takes effect only after store and power cycle.
// (R22) Pin action bit 0 soft turn-off, 1 immediate turn-off.
`include "ooc_map.svh"
module ooc_top #(parameter logic [6:0] DEV_ADDR = 7'h24) (
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    output logic ALERT_B_OUT,
    input wire logic CONTROL_PIN_IN,
    input wire logic LOOP_FOLLOWER_IN,
    input wire logic [4:0] NV_CONFIG_IN,
    input wire logic UVLO_OK_IN,
    input wire logic FAULT_IN,
    input wire logic UV_EVENT_IN,
    input wire logic OV_EVENT_IN,
    input wire logic UV_ALERT_MASK_IN,
    input wire logic OV_ALERT_MASK_IN,
    input wire logic signed [15:0] NOMINAL_IN,
    input wire logic signed [15:0] TRIM_IN,
    input wire logic signed [15:0] STEP_HIGH_IN,
    input wire logic signed [15:0] STEP_LOW_IN,
    input wire logic [3:0] SCALE_SHIFT_IN,
    input wire logic [15:0] TOFF_DELAY_IN,
    input wire logic [15:0] TOFF_FALL_IN,
    output logic DRIVE_HS_EN_OUT,
    output logic DRIVE_LS_EN_OUT,
    output logic RAMP_DOWN_OUT,
    output logic [15:0] TARGET_OUT,
    output logic FAULT_RESPOND_OUT,
    output logic STORE_ALL_OUT,
    output logic [4:0] CONFIG_STORE_OUT,
    output logic UV_FLAG_OUT,
    output logic OV_FLAG_OUT,
    output logic CML_FLAG_OUT,
    output logic IVD_FLAG_OUT,
    output logic IVC_FLAG_OUT
);
    function automatic ooc_pkg::ooc_mdec_t mgn_dec(input logic [3:0] f);
        ooc_pkg::ooc_mdec_t d;
        d.valid = 1'b1;
        d.ignore = 1'b0;
        d.sel = ooc_pkg::MG_NOM;
        case (f)
            `OOC_MG_NOM_IGN: d.ignore = 1'b1; // R09
            `OOC_MG_NOM_A, `OOC_MG_NOM_B, `OOC_MG_NOM_C: d.ignore = 1'b0; // R10
            `OOC_MG_LO_IGN: begin // R11
                d.sel = ooc_pkg::MG_LO;
                d.ignore = 1'b1;
            end
            `OOC_MG_LO_ACT: d.sel = ooc_pkg::MG_LO; // R11
            `OOC_MG_HI_IGN: begin // R12
                d.sel = ooc_pkg::MG_HI;
                d.ignore = 1'b1;
            end
            `OOC_MG_HI_ACT: d.sel = ooc_pkg::MG_HI; // R12
            default: d.valid = 1'b0; // R13
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [2:0] pins;
    logic scl, sda, cpin, scl_d, sda_d;
    ooc_sync #(.W(3)) u_sync (
        .clk_in(MCLK_IN),
        .rst_b_in(RST_B_IN),
        .d_in({CONTROL_PIN_IN, SDA_IN, SCL_IN}),
        .q_out(pins)
    );
    assign scl = pins[0];
    assign sda = pins[1];
    assign cpin = pins[2];

    ooc_pkg::ooc_bus_st_t bst;
    logic [7:0] sh, cmd, tx, op;
    logic [3:0] cnt;
    logic [1:0] byte_n;
    logic rd, m_ack, sda_oe;
    logic [4:0] cfg;
    logic follower, pol_eff, booted;
    logic uv_f, ov_f, cml_f, ivd_f, ivc_f;

    wire scl_rise = scl && !scl_d;
    wire scl_fall = !scl && scl_d;
    wire start_cond = scl && scl_d && sda_d && !sda;
    wire stop_cond = scl && scl_d && !sda_d && sda;
    wire byte_done = (bst == ooc_pkg::BS_RX) && (cnt == `OOC_BIT_FULL) && scl_fall;
    wire addr_hit = (sh[7:1] == DEV_ADDR);
    wire op_or_cfg = (sh == `OOC_REG_OP) || (sh == `OOC_REG_CFG);
    wire cmd_blocked = follower && op_or_cfg; // R02
    wire ack_now = (byte_n == 2'h0) ? addr_hit : (byte_n == 2'h1) ? !cmd_blocked : 1'b1;
    wire cmd_go = byte_done && (byte_n == 2'h1) && !cmd_blocked;
    wire clr_go = cmd_go && (sh == `OOC_CMD_CLEAR);
    wire store_go = cmd_go && (sh == `OOC_CMD_STORE);
    wire ivc_set = byte_done && (byte_n == 2'h1) && cmd_blocked; // R02
    wire data_wr = byte_done && (byte_n == 2'h2) && !rd;
    wire wr_op = data_wr && (cmd == `OOC_REG_OP);
    wire wr_cfg = data_wr && (cmd == `OOC_REG_CFG);
    ooc_pkg::ooc_mdec_t wr_dec, op_dec;
    assign wr_dec = mgn_dec(sh[`OOC_OP_MG_HI:`OOC_OP_MG_LO]);
    assign op_dec = mgn_dec(op[`OOC_OP_MG_HI:`OOC_OP_MG_LO]);
    wire both_set = sh[`OOC_OP_ON] && sh[`OOC_OP_OFF];
    wire ivd_set = wr_op && (both_set || !wr_dec.valid); // R08 R13
    wire [7:0] rd_data = (cmd == `OOC_REG_OP) ? op :
                         (cmd == `OOC_REG_CFG) ? {3'h0, cfg} : 8'h00; // R18

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    // The ack flag doubles as the SDA pull-down, so acked and driven never disagree
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            bst <= ooc_pkg::BS_IDLE;
            sh <= 8'h00;
            cmd <= 8'h00;
            tx <= 8'h00;
            cnt <= 4'h0;
            byte_n <= 2'h0;
            rd <= 1'b0;
            m_ack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_cond) begin
            bst <= ooc_pkg::BS_RX;
            cnt <= 4'h0;
            byte_n <= 2'h0;
            rd <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            bst <= ooc_pkg::BS_IDLE;
            sda_oe <= 1'b0;
        end else begin
            unique case (bst)
                ooc_pkg::BS_IDLE: begin
                end
                ooc_pkg::BS_RX: begin
                    if (scl_rise && !cnt[3]) begin
                        sh <= {sh[6:0], sda};
                        cnt <= cnt + 4'h1;
                    end else if (byte_done) begin
                        bst <= ooc_pkg::BS_ACK;
                        sda_oe <= ack_now; // R02
                        if (byte_n == 2'h0) rd <= sh[0];
                        if (byte_n == 2'h1) cmd <= sh;
                    end
                end
                ooc_pkg::BS_ACK: if (scl_fall) begin
                    cnt <= 4'h0;
                    if (!sda_oe) begin
                        bst <= ooc_pkg::BS_IDLE;
                    end else if (rd) begin
                        bst <= ooc_pkg::BS_TX;
                        tx <= rd_data;
                        sda_oe <= !rd_data[7];
                    end else begin
                        bst <= ooc_pkg::BS_RX;
                        sda_oe <= 1'b0;
                        if (byte_n != 2'h3) byte_n <= byte_n + 2'h1;
                    end
                end
                ooc_pkg::BS_TX: if (scl_fall) begin
                    if (cnt == `OOC_BIT_LAST) begin
                        bst <= ooc_pkg::BS_RACK;
                        sda_oe <= 1'b0;
                    end else begin
                        tx <= {tx[6:0], 1'b0};
                        cnt <= cnt + 4'h1;
                        sda_oe <= !tx[6];
                    end
                end
                ooc_pkg::BS_RACK: begin
                    if (scl_rise) m_ack <= !sda;
                    if (scl_fall && m_ack) begin
                        bst <= ooc_pkg::BS_TX;
                        tx <= rd_data;
                        cnt <= 4'h0;
                        sda_oe <= !rd_data[7];
                    end else if (scl_fall) begin
                        bst <= ooc_pkg::BS_IDLE;
                    end
                end
                default: bst <= ooc_pkg::BS_IDLE;
            endcase
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = sda_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Strap and stored config are taken on the first edge after release, never in reset
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            booted <= 1'b0;
            follower <= 1'b0;
            pol_eff <= 1'b1;
            cfg <= `OOC_CFG_RST; // R17
            op <= `OOC_OP_RST;
        end else if (!booted) begin
            booted <= 1'b1;
            follower <= LOOP_FOLLOWER_IN;
            cfg <= NV_CONFIG_IN;
            pol_eff <= NV_CONFIG_IN[`OOC_CFG_POL]; // R21
        end else begin
            if (wr_op && !ivd_set) op <= sh & `OOC_OP_RO_MASK; // R01 R07
            if (wr_cfg) cfg <= sh[4:0]; // R18
        end
    end

    // Status flags: a new event wins over a clear in the same cycle
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            uv_f <= 1'b0;
            ov_f <= 1'b0;
            cml_f <= 1'b0;
            ivd_f <= 1'b0;
            ivc_f <= 1'b0;
        end else begin
            uv_f <= UV_EVENT_IN || (uv_f && !clr_go); // R16
            ov_f <= OV_EVENT_IN || (ov_f && !clr_go); // R16
            ivd_f <= ivd_set || (ivd_f && !clr_go); // R08
            ivc_f <= ivc_set || (ivc_f && !clr_go); // R02
            cml_f <= ivd_set || ivc_set || (cml_f && !clr_go);
        end
    end

    wire alert_now = (uv_f && !UV_ALERT_MASK_IN) || (ov_f && !OV_ALERT_MASK_IN) ||
                     cml_f || ivd_f || ivc_f; // R16

    ////////////////////////////////////////////////////////////////////////////
    wire pin_act = pol_eff ? cpin : !cpin; // R21
    wire cmd_gate = !cfg[`OOC_CFG_CMD] || op[`OOC_OP_ON]; // R20
    wire pin_gate = !cfg[`OOC_CFG_CPR] || pin_act; // R20
    wire power_ok = UVLO_OK_IN && !FAULT_IN; // R04
    wire gated_on = !cfg[`OOC_CFG_PU] || (cmd_gate && pin_gate); // R19
    // When command and pin drop together the command's turn-off style wins
    wire cmd_soft = !cmd_gate && op[`OOC_OP_OFF]; // R05 R06
    wire pin_soft = cmd_gate && !pin_gate && !cfg[`OOC_CFG_CPA]; // R22

    ooc_seq_if sqi();
    assign sqi.run_req = power_ok && gated_on; // R03 R04
    assign sqi.soft_off = power_ok && cfg[`OOC_CFG_PU] && (cmd_soft || pin_soft);
    assign sqi.dly = TOFF_DELAY_IN;
    assign sqi.fall = TOFF_FALL_IN;
    ooc_seq u_seq (
        .clk_in(MCLK_IN),
        .rst_b_in(RST_B_IN),
        .sq(sqi.seq)
    );

    // Scaling is an arithmetic shift, so the loop scale must be a power of two
    wire signed [16:0] lo_off = 17'(TRIM_IN) - 17'(STEP_LOW_IN); // R14
    wire signed [16:0] hi_off = 17'(TRIM_IN) + 17'(STEP_HIGH_IN); // R15
    wire signed [16:0] sel_off = (op_dec.sel == ooc_pkg::MG_LO) ? (lo_off >>> SCALE_SHIFT_IN) :
                                 (op_dec.sel == ooc_pkg::MG_HI) ? (hi_off >>> SCALE_SHIFT_IN) :
                                 17'sh00000;
    wire signed [16:0] next_target = 17'(NOMINAL_IN) + sel_off;

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            DRIVE_HS_EN_OUT <= 1'b0;
            DRIVE_LS_EN_OUT <= 1'b0;
            RAMP_DOWN_OUT <= 1'b0;
            TARGET_OUT <= 16'h0000;
            FAULT_RESPOND_OUT <= 1'b0;
            STORE_ALL_OUT <= 1'b0;
            ALERT_B_OUT <= 1'b1;
        end else begin
            DRIVE_HS_EN_OUT <= sqi.switching; // R03
            DRIVE_LS_EN_OUT <= sqi.switching; // R03
            RAMP_DOWN_OUT <= sqi.ramping;
            TARGET_OUT <= next_target[15:0]; // R14 R15
            FAULT_RESPOND_OUT <= (UV_EVENT_IN || OV_EVENT_IN) && !op_dec.ignore; // R16
            STORE_ALL_OUT <= store_go; // R18
            ALERT_B_OUT <= !alert_now;
        end
    end

    assign CONFIG_STORE_OUT = cfg;
    assign UV_FLAG_OUT = uv_f;
    assign OV_FLAG_OUT = ov_f;
    assign CML_FLAG_OUT = cml_f;
    assign IVD_FLAG_OUT = ivd_f;
    assign IVC_FLAG_OUT = ivc_f;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    follower_nack_a: assert property ( // R02
        ivc_set |=> (IVC_FLAG_OUT && CML_FLAG_OUT && !SDA_OE_OUT) ##1 !ALERT_B_OUT)
        else $error("follower access not refused");
    driver_off_a: assert property ( // R03
        !sqi.switching |=> !DRIVE_HS_EN_OUT && !DRIVE_LS_EN_OUT)
        else $error("drivers active while not switching");
    op_write_a: assert property ( // R07
        (wr_op && !ivd_set) |=> op == ($past(sh) & `OOC_OP_RO_MASK))
        else $error("on/off-margin write stored wrong value");
    both_bits_a: assert property ( // R08
        (wr_op && both_set) |=> IVD_FLAG_OUT && $stable(op) ##1 !ALERT_B_OUT)
        else $error("on and off both set not rejected");
    bad_margin_a: assert property ( // R13
        (wr_op && !wr_dec.valid) |=> IVD_FLAG_OUT && $stable(op))
        else $error("invalid margin code accepted");
    uv_alert_a: assert property ( // R16
        (UV_EVENT_IN && !UV_ALERT_MASK_IN) ##1 !UV_ALERT_MASK_IN |->
        UV_FLAG_OUT ##1 !ALERT_B_OUT)
        else $error("ignored undervoltage did not alert");
    cfg_write_a: assert property ( // R18
        wr_cfg |=> {3'h0, cfg} == ($past(sh) & 8'h1f))
        else $error("config write stored wrong value");
    pol_hold_a: assert property ( // R21
        (booted && $past(booted)) |-> $stable(pol_eff))
        else $error("pin polarity changed without power cycle");
    cmd_gate_a: assert property ( // R20
        (cfg[`OOC_CFG_PU] && cfg[`OOC_CFG_CMD] && !op[`OOC_OP_ON] &&
        !sqi.switching) |=> !sqi.switching)
        else $error("switching without command enable");

    high_margin_c: cover property (wr_op && wr_dec.sel == ooc_pkg::MG_HI && !ivd_set);
    follower_c: cover property (ivc_set);
    read_c: cover property (bst == ooc_pkg::BS_RACK ##[1:300] bst == ooc_pkg::BS_TX);
    ramp_c: cover property ($rose(RAMP_DOWN_OUT));
endmodule

/* File: verif/ooc_host.sv */
module ooc_host #(parameter logic [6:0] ADDR = 7'h24) (
    output logic scl_out,
    output logic sda_out,
    input wire logic sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock stands high between frames; a released data line reads as pulled up
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task bit_x(input logic b, output logic r);
        sda_out = b;
        #31.25 scl_out = 1'b1;
        #31.25 r = sda_in;
        #31.25 scl_out = 1'b0;
        #31.25;
    endtask
    task byte_x(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bit_x(d[i], q[i]);
    endtask
    task edge_x(input logic a, input logic b);
        sda_out = a;
        #31.25 scl_out = 1'b1;
        #31.25 sda_out = b;
        #31.25;
    endtask
    task start_x();
        edge_x(1'h1, 1'h0);
        scl_out = 1'b0;
        #31.25;
    endtask
    // Kind 0 writes a byte, 1 reads one back through a repeated start, 2 sends the command alone
    task xfer(input logic [1:0] kind, input logic [7:0] cmd, input logic [7:0] dat,
              output logic [7:0] rd, output logic ack);
        logic [8:0] q;
        // Off-grid offset keeps every pin change away from a clock edge
        #0.125;
        start_x();
        byte_x({ADDR, 2'h1}, q);
        byte_x({cmd, 1'h1}, q);
        ack = ~q[0];
        rd = 8'h00;
        if (kind == 2'h0) byte_x({dat, 1'h1}, q);
        if (kind == 2'h1) begin
            start_x();
            byte_x({ADDR, 2'h3}, q);
            byte_x(9'h1ff, q);
            rd = q[8:1];
        end
        edge_x(1'h0, 1'h1);
    endtask
endmodule

/* File: verif/ooc_top_test.sv */
module ooc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst_b = 1'b0, pin = 1'b1, lf = 1'b0, uvlo = 1'b1, flt = 1'b0;
    logic uv = 1'b0, ov = 1'b0, uvm = 1'b0, ovm = 1'b0, ack;
    logic [4:0] nvc = 5'h1e;
    logic [3:0] sh = 4'h1;
    logic signed [15:0] nom = 16'h0100, trim = 16'h0010, sth = 16'h0020, stl = 16'h0008, et;
    logic [15:0] tdl = 16'h0100;
    logic [7:0] rd, last;
    logic [11:0] row;
    // Row: data byte, invalid flag, ignore-fault flag, setpoint select (1 low, 2 high)
    logic [11:0] rows [15] = '{12'h030, 12'h074, 12'h0b0, 12'h0f0, 12'h175, 12'h138, 12'h1b1,
        12'h1f8, 12'h276, 12'h238, 12'h2b2, 12'h2f8, 12'h338, 12'h3f8, 12'hc08};
    int errors = 0, total_checks = 0, n, fr_cnt = 0, st_cnt = 0, rp_cnt = 0, c0;
    wire scl, sda_h, sda_oe, sda_d, hs, ls, ramp, alert_b, fr, st, undervoltage_fault_flag, ovf, cml, ivd, invalid_command_fault;
    wire [15:0] tgt;
    wire [4:0] cfg;
    wire sda = sda_h & (sda_oe ? sda_d : 1'b1);
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        if (fr === 1'b1) fr_cnt <= fr_cnt + 1;
        if (st === 1'b1) st_cnt <= st_cnt + 1;
        if (ramp === 1'b1) rp_cnt <= rp_cnt + 1;
    end
    ooc_host i_ooc_host (.scl_out(scl), .sda_out(sda_h), .sda_in(sda));
    ooc_top i_ooc_top (.MCLK_IN(mclk), .RST_B_IN(rst_b), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_d), .SDA_OE_OUT(sda_oe), .ALERT_B_OUT(alert_b), .CONTROL_PIN_IN(pin),
        .LOOP_FOLLOWER_IN(lf), .NV_CONFIG_IN(nvc), .UVLO_OK_IN(uvlo), .FAULT_IN(flt),
        .UV_EVENT_IN(uv), .OV_EVENT_IN(ov), .UV_ALERT_MASK_IN(uvm), .OV_ALERT_MASK_IN(ovm),
        .NOMINAL_IN(nom), .TRIM_IN(trim), .STEP_HIGH_IN(sth), .STEP_LOW_IN(stl),
        .SCALE_SHIFT_IN(sh), .TOFF_DELAY_IN(tdl), .TOFF_FALL_IN(tdl), .DRIVE_HS_EN_OUT(hs),
        .DRIVE_LS_EN_OUT(ls), .RAMP_DOWN_OUT(ramp), .TARGET_OUT(tgt), .FAULT_RESPOND_OUT(fr),
        .STORE_ALL_OUT(st), .CONFIG_STORE_OUT(cfg), .UV_FLAG_OUT(undervoltage_fault_flag), .OV_FLAG_OUT(ovf),
        .CML_FLAG_OUT(cml), .IVD_FLAG_OUT(ivd), .IVC_FLAG_OUT(invalid_command_fault));
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test();
        $display("Checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task op(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d);
        i_ooc_host.xfer(k, c, d, rd, ack);
        repeat (4) @(posedge mclk);
    endtask
    task pulse(input logic o);
        if (o) ov <= 1'b1;
        else uv <= 1'b1;
        @(posedge mclk);
        ov <= 1'b0;
        uv <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    // Bounded wait on the high-side enable; a timeout ends the run at once
    task wait_hs(input logic v);
        for (n = 0; n < 600 && hs !== v; n++) @(posedge mclk);
        chk(hs, v);
        if (hs !== v) stop_test();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk);
        chk(cfg, 5'h16);
        rst_b <= 1'b1;
        repeat (12) @(posedge mclk);
        chk(cfg, nvc);
        for (int i = 0; i < 15; i++) begin
            row = rows[i];
            op(2'h2, 8'h03, 8'h00);
            op(2'h0, 8'h01, row[11:4]);
            chk(ivd, row[3]);
            chk({cml, alert_b}, {row[3], !row[3]});
            if (!row[3]) last = row[11:4] & 8'hfc;
            op(2'h1, 8'h01, 8'h00);
            chk(rd, last);
            if (!row[3]) begin
                et = row[1] ? nom + ((trim + sth) >>> sh) : nom + ((trim - stl) >>> sh);
                chk(tgt, row[1] | row[0] ? et : nom);
                c0 = fr_cnt;
                pulse(row[1]);
                chk(row[1] ? ovf : undervoltage_fault_flag, 1'b1);
                chk(alert_b, 1'b0);
                chk(fr_cnt != c0, !row[2]);
            end
        end
        op(2'h2, 8'h03, 8'h00);
        uvm <= 1'b1;
        pulse(1'b0);
        chk({undervoltage_fault_flag, alert_b}, 2'h3);
        flt <= 1'b1;
        op(2'h0, 8'h01, 8'h80);
        chk(hs, 1'b0);
        flt <= 1'b0;
        uvlo <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(hs, 1'b0);
        uvlo <= 1'b1;
        wait_hs(1'b1);
        chk(ls, 1'b1);
        c0 = rp_cnt;
        op(2'h0, 8'h01, 8'h00);
        chk(hs | ls, 1'b0);
        chk(rp_cnt != c0, 1'b0);
        op(2'h0, 8'h01, 8'h80);
        wait_hs(1'b1);
        op(2'h0, 8'h01, 8'h40);
        chk(hs, 1'b1);
        c0 = rp_cnt;
        wait_hs(1'b0);
        chk(16'(rp_cnt - c0), tdl + 16'h0001);
        op(2'h0, 8'h01, 8'h80);
        wait_hs(1'b1);
        pin <= 1'b0;
        repeat (40) @(posedge mclk);
        chk(hs, 1'b1);
        wait_hs(1'b0);
        pin <= 1'b1;
        wait_hs(1'b1);
        // Polarity bit cleared here must not flip the pin until a power cycle
        op(2'h0, 8'h02, 8'hfd);
        op(2'h1, 8'h02, 8'h00);
        chk(rd, 8'h1d);
        chk(hs, 1'b1);
        c0 = st_cnt;
        op(2'h2, 8'h11, 8'h00);
        chk(16'(st_cnt - c0), 16'h0001);
        pin <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(hs, 1'b0);
        op(2'h0, 8'h02, 8'h00);
        wait_hs(1'b1);
        rst_b <= 1'b0;
        lf <= 1'b1;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (12) @(posedge mclk);
        op(2'h0, 8'h02, 8'h00);
        chk(ack, 1'b0);
        chk(invalid_command_fault & cml & ~alert_b, 1'b1);
        stop_test();
    end
endmodule
